// ==== logic/deem_monitor.sv ====
// Exception-event monitor: profile timers, protection, uninitialized reads,
// stack checks and event routing to break and trace conditions.
// Assumes bus and core status come from logic on the same clock.
`timescale 1ns/1ps

// Notes on behaviour
// - Execution time is a 40-bit counter advanced once per selected tick.
// - Tick is 10, 20, 40, 80, 160 ns or 1.6 us, selectable.
// - Call count is a 16-bit counter, largest value 65535.
// - Profile overflow raised when profiled time or count passes its limit.
// - Performance overflow raised, time-out and count-out reported separately.
// - Each enabled event may act as break and as trace-point condition.
// - Each protected word carries read-write, read-only, write-only, none or OS.
// - A read, write or fetch not allowed by the attribute is a violation.
// - On OS-only words any access not made by the OS is a violation.
// - After reset every word is read-write, so nothing is flagged.
// - Protection uses sixteen range blocks; unlisted words stay unchecked.
// - Reading a monitored word never written raises an uninitialized event.
// - Up to thirty-two monitor blocks, numbered from zero, 8 Kbytes total.
// - Stack pointer leaving the configured stack area raises an event.
// - A write into a task stack by another task raises an event.
// - Trace storage filling beyond capacity raises an event.
// - Each task switch by the OS raises a dispatch event.
// - Changing the resolution clears all accumulated profile results.
module deem_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire deem_pkg::deem_res_t res_sel,
   input wire logic clear,
   input wire logic prof_active,
   input wire logic prof_call,
   input wire logic perf_active,
   input wire logic perf_enter,
   input wire deem_pkg::deem_access_t access,
   input wire deem_pkg::deem_prot_cfg_t [deem_pkg::PROT_N-1:0] prot_cfg,
   input wire logic [deem_pkg::UNI_N-1:0] uni_blk_en,
   input wire logic [deem_pkg::UNI_N-1:0][deem_pkg::ADDR_W-1:0] uni_blk_base,
   input wire logic uni_clear,
   input wire logic [deem_pkg::ADDR_W-1:0] sp,
   input wire logic [deem_pkg::ADDR_W-1:0] stack_lo,
   input wire logic [deem_pkg::ADDR_W-1:0] stack_hi,
   input wire logic stack_en,
   input wire deem_pkg::deem_tstack_cfg_t tstack_cfg,
   input wire logic [deem_pkg::TASK_W-1:0] run_task,
   input wire logic trace_write,
   input wire logic trace_full,
   input wire logic [deem_pkg::EVT_N-1:0] evt_en,
   input wire logic [deem_pkg::EVT_N-1:0] brk_sel,
   input wire logic [deem_pkg::EVT_N-1:0] trc_sel,
   output logic [deem_pkg::TIME_W-1:0] prof_time,
   output logic [deem_pkg::CNT_W-1:0] prof_count,
   output logic [deem_pkg::TIME_W-1:0] perf_time,
   output logic [deem_pkg::CNT_W-1:0] perf_count,
   output logic [deem_pkg::EVT_N-1:0] evt_pulse,
   output logic [deem_pkg::EVT_N-1:0] evt_sticky,
   output logic break_req,
   output logic trace_point
);

   // Saturating add: holds at the top rather than wrapping
   function automatic logic [deem_pkg::TIME_W-1:0] sat_add(
      input logic [deem_pkg::TIME_W-1:0] v,
      input logic [deem_pkg::TIME_W-1:0] step,
      output logic ovf);
      logic [deem_pkg::TIME_W:0] s;
      s = {1'b0, v} + {1'b0, step};
      ovf = s[deem_pkg::TIME_W];
      sat_add = ovf ? deem_pkg::TIME_MAX : s[deem_pkg::TIME_W-1:0];
   endfunction

   function automatic logic in_range(
      input logic [deem_pkg::ADDR_W-1:0] a,
      input logic [deem_pkg::ADDR_W-1:0] lo,
      input logic [deem_pkg::ADDR_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Tick generator
   logic [7:0] div_q;
   logic [7:0] div_lim;
   logic tick;
   logic [deem_pkg::TIME_W-1:0] step;
   deem_pkg::deem_res_t res_q;
   logic res_chg;

   always_comb begin
      case (res_sel)
         deem_pkg::DEEM_RES_10NS: div_lim = deem_pkg::DIV0;
         deem_pkg::DEEM_RES_20NS: div_lim = deem_pkg::DIV1;
         deem_pkg::DEEM_RES_40NS: div_lim = deem_pkg::DIV2;
         deem_pkg::DEEM_RES_80NS: div_lim = deem_pkg::DIV3;
         deem_pkg::DEEM_RES_160NS: div_lim = deem_pkg::DIV4;
         deem_pkg::DEEM_RES_1U6: div_lim = deem_pkg::DIV5;
         default: div_lim = deem_pkg::DIV1;
      endcase
   end

   assign res_chg = (res_sel != res_q);
   assign tick = (div_q == div_lim - 8'h01);
   assign step = (res_sel == deem_pkg::DEEM_RES_10NS) ?
                 deem_pkg::STEP_FINE : deem_pkg::STEP_ONE;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         res_q <= deem_pkg::DEEM_RES_10NS;
      end else begin
         res_q <= res_sel;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 8'h00;
      end else if (res_chg || tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // Profile and performance counters
   logic [deem_pkg::TIME_W-1:0] prof_t_q;
   logic [deem_pkg::TIME_W-1:0] perf_t_q;
   logic [deem_pkg::CNT_W-1:0] prof_c_q;
   logic [deem_pkg::CNT_W-1:0] perf_c_q;
   logic prof_ovf_q;
   logic perf_tout_q;
   logic perf_cout_q;
   logic [deem_pkg::TIME_W-1:0] prof_t_d;
   logic [deem_pkg::TIME_W-1:0] perf_t_d;
   logic prof_t_ovf;
   logic perf_t_ovf;
   logic prof_c_hit;
   logic perf_c_hit;
   logic prof_clr;

   assign prof_clr = clear || res_chg;

   always_comb begin
      prof_t_d = sat_add(prof_t_q, step, prof_t_ovf);
      perf_t_d = sat_add(perf_t_q, step, perf_t_ovf);
   end

   assign prof_c_hit = prof_call && (prof_c_q == deem_pkg::CNT_MAX);
   assign perf_c_hit = perf_enter && (perf_c_q == deem_pkg::CNT_MAX);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prof_t_q <= '0;
         prof_c_q <= '0;
      end else if (prof_clr) begin
         prof_t_q <= '0;
         prof_c_q <= '0;
      end else begin
         if (prof_active && tick)
            prof_t_q <= prof_t_d;
         if (prof_call && !prof_c_hit)
            prof_c_q <= prof_c_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         perf_t_q <= '0;
         perf_c_q <= '0;
      end else if (prof_clr) begin
         perf_t_q <= '0;
         perf_c_q <= '0;
      end else begin
         if (perf_active && tick)
            perf_t_q <= perf_t_d;
         if (perf_enter && !perf_c_hit)
            perf_c_q <= perf_c_q + 16'h0001;
      end
   end

   logic prof_ovf_ev;
   logic perf_tout_ev;
   logic perf_cout_ev;
   assign prof_ovf_ev = (prof_active && tick && prof_t_ovf) || prof_c_hit;
   assign perf_tout_ev = perf_active && tick && perf_t_ovf;
   assign perf_cout_ev = perf_c_hit;

   // Overflow stays until results are cleared; a new overflow beats a clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prof_ovf_q <= 1'b0;
         perf_tout_q <= 1'b0;
         perf_cout_q <= 1'b0;
      end else begin
         prof_ovf_q <= prof_ovf_ev || (prof_ovf_q && !prof_clr);
         perf_tout_q <= perf_tout_ev || (perf_tout_q && !prof_clr);
         perf_cout_q <= perf_cout_ev || (perf_cout_q && !prof_clr);
      end
   end

   // Access protection; with no block enabled every word is read-write
   logic prot_viol;
   always_comb begin
      deem_pkg::deem_attr_t attr;
      attr = deem_pkg::DEEM_ATTR_RW;
      // Lowest block wins where ranges overlap
      for (int i = deem_pkg::PROT_N - 1; i >= 0; i--) begin
         if (prot_cfg[i].en &&
             in_range(access.addr, prot_cfg[i].lo, prot_cfg[i].hi))
            attr = prot_cfg[i].attr;
      end
      prot_viol = 1'b0;
      if (access.valid) begin
         case (attr)
            deem_pkg::DEEM_ATTR_RW: prot_viol = 1'b0;
            deem_pkg::DEEM_ATTR_RO: prot_viol = access.wr;
            deem_pkg::DEEM_ATTR_WO: prot_viol = access.rd || access.fetch;
            deem_pkg::DEEM_ATTR_NONE: prot_viol = 1'b1;
            deem_pkg::DEEM_ATTR_OS: prot_viol = !access.from_os;
            default: prot_viol = 1'b0;
         endcase
      end
   end

   // Uninitialized read: one written bit per monitored byte
   logic [deem_pkg::UNI_WORDS-1:0] written_q;
   logic uni_hit;
   logic [deem_pkg::UNI_IDX_W-1:0] uni_idx;
   logic [deem_pkg::ADDR_W-1:0] uni_off;

   always_comb begin
      uni_hit = 1'b0;
      uni_idx = '0;
      uni_off = '0;
      for (int b = 0; b < deem_pkg::UNI_N; b++) begin
         uni_off = access.addr - uni_blk_base[b];
         if (!uni_hit && uni_blk_en[b] &&
             uni_off < deem_pkg::ADDR_W'(1 << deem_pkg::UNI_BLK_W)) begin
            uni_hit = 1'b1;
            uni_idx = {5'(b), uni_off[deem_pkg::UNI_BLK_W-1:0]};
         end
      end
   end

   // History is only dropped as a whole: clear it after moving a block
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         written_q <= '0;
      end else begin
         if (uni_clear)
            written_q <= '0;
         if (access.valid && access.wr && uni_hit)
            written_q[uni_idx] <= 1'b1;
      end
   end

   logic uni_ev;
   assign uni_ev = access.valid && access.rd && uni_hit &&
                   !written_q[uni_idx];

   // Stack, task stack, trace and dispatch
   logic stack_ev;
   logic tstack_ev;
   logic trace_ev;
   logic disp_ev;
   logic [deem_pkg::TASK_W-1:0] task_q;
   logic task_vld_q;

   assign stack_ev = stack_en && !in_range(sp, stack_lo, stack_hi);
   assign tstack_ev = tstack_cfg.en && access.valid && access.wr &&
                      in_range(access.addr, tstack_cfg.lo, tstack_cfg.hi) &&
                      (run_task != tstack_cfg.owner);
   assign trace_ev = trace_write && trace_full;
   // No task is known before the first edge, so no switch is seen there
   assign disp_ev = task_vld_q && (run_task != task_q);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         task_q <= '0;
         task_vld_q <= 1'b0;
      end else begin
         task_q <= run_task;
         task_vld_q <= 1'b1;
      end
   end

   // Event collection and routing
   logic [deem_pkg::EVT_N-1:0] raw_ev;
   logic [deem_pkg::EVT_N-1:0] pulse_q;
   logic [deem_pkg::EVT_N-1:0] sticky_q;
   logic brk_q;
   logic trc_q;

   always_comb begin
      raw_ev = '0;
      raw_ev[deem_pkg::EV_PROT] = prot_viol;
      raw_ev[deem_pkg::EV_UNINIT] = uni_ev;
      raw_ev[deem_pkg::EV_STACK] = stack_ev;
      raw_ev[deem_pkg::EV_PERF_TIME] = perf_tout_ev;
      raw_ev[deem_pkg::EV_PERF_CNT] = perf_cout_ev;
      raw_ev[deem_pkg::EV_PROF] = prof_ovf_ev;
      raw_ev[deem_pkg::EV_TRACE] = trace_ev;
      raw_ev[deem_pkg::EV_TSTACK] = tstack_ev;
      raw_ev[deem_pkg::EV_DISPATCH] = disp_ev;
      raw_ev = raw_ev & evt_en;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pulse_q <= '0;
         sticky_q <= '0;
         brk_q <= 1'b0;
         trc_q <= 1'b0;
      end else begin
         pulse_q <= raw_ev;
         sticky_q <= raw_ev | (clear ? '0 : sticky_q);
         brk_q <= |(raw_ev & brk_sel);
         trc_q <= |(raw_ev & trc_sel);
      end
   end

   assign prof_time = prof_t_q;
   assign prof_count = prof_c_q;
   assign perf_time = perf_t_q;
   assign perf_count = perf_c_q;
   assign evt_pulse = pulse_q;
   logic [deem_pkg::EVT_N-1:0] ovf_hold;
   always_comb begin
      ovf_hold = '0;
      ovf_hold[deem_pkg::EV_PROF] = prof_ovf_q;
      ovf_hold[deem_pkg::EV_PERF_TIME] = perf_tout_q;
      ovf_hold[deem_pkg::EV_PERF_CNT] = perf_cout_q;
   end
   assign evt_sticky = sticky_q | (ovf_hold & evt_en);
   assign break_req = brk_q;
   assign trace_point = trc_q;

endmodule

// ==== logic/deem_pkg.sv ====
// Package for the exception-event monitor: widths, encodings, carriers.
// Assumes one 50 MHz clock shared by all monitor logic.
package deem_pkg;
   localparam int CLK_NS = 20;
   localparam int TIME_W = 40;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 24;
   localparam int PROT_N = 16;
   localparam int UNI_N = 32;
   localparam int UNI_WORDS = 8192;
   localparam int UNI_IDX_W = 13;
   localparam int UNI_BLK_W = 8;
   localparam int EVT_N = 9;
   localparam int TASK_W = 8;
   localparam logic [TIME_W-1:0] TIME_MAX = {TIME_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   // Tick periods in ns, figures as printed
   localparam int RES0_NS = 10;
   localparam int RES1_NS = 20;
   localparam int RES2_NS = 40;
   localparam int RES3_NS = 80;
   localparam int RES4_NS = 160;
   localparam int RES5_NS = 1600;
   // Cycles per tick; 10 ns is finer than the clock, so it adds two per edge
   localparam logic [7:0] DIV0 = 8'(1);
   localparam logic [7:0] DIV1 = 8'(RES1_NS / CLK_NS);
   localparam logic [7:0] DIV2 = 8'(RES2_NS / CLK_NS);
   localparam logic [7:0] DIV3 = 8'(RES3_NS / CLK_NS);
   localparam logic [7:0] DIV4 = 8'(RES4_NS / CLK_NS);
   localparam logic [7:0] DIV5 = 8'(RES5_NS / CLK_NS);
   localparam logic [TIME_W-1:0] STEP_FINE = 40'(CLK_NS / RES0_NS);
   localparam logic [TIME_W-1:0] STEP_ONE = 40'h1;

   typedef enum logic [2:0] {
      DEEM_RES_10NS, DEEM_RES_20NS, DEEM_RES_40NS,
      DEEM_RES_80NS, DEEM_RES_160NS, DEEM_RES_1U6
   } deem_res_t;

   typedef enum logic [2:0] {
      DEEM_ATTR_RW, DEEM_ATTR_RO, DEEM_ATTR_WO,
      DEEM_ATTR_NONE, DEEM_ATTR_OS
   } deem_attr_t;

   // Event bit positions
   localparam int EV_PROT = 0;
   localparam int EV_UNINIT = 1;
   localparam int EV_STACK = 2;
   localparam int EV_PERF_TIME = 3;
   localparam int EV_PERF_CNT = 4;
   localparam int EV_PROF = 5;
   localparam int EV_TRACE = 6;
   localparam int EV_TSTACK = 7;
   localparam int EV_DISPATCH = 8;

   typedef struct packed {
      logic valid;
      logic rd;
      logic wr;
      logic fetch;
      logic from_os;
      logic [ADDR_W-1:0] addr;
   } deem_access_t;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] lo;
      logic [ADDR_W-1:0] hi;
      deem_attr_t attr;
   } deem_prot_cfg_t;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] lo;
      logic [ADDR_W-1:0] hi;
      logic [TASK_W-1:0] owner;
   } deem_tstack_cfg_t;
endpackage

// ==== test/deem_core_model.sv ====
// Emulated core: replays bench-requested accesses, stack pointer and task.
// Assumes the bench raises an access request for one cycle at a time.
`timescale 1ns/1ps
module deem_core_model (
   input wire logic clk,
   input wire logic rstn,
   input wire deem_pkg::deem_access_t req,
   input wire logic [23:0] sp_req,
   input wire logic [7:0] task_req,
   output deem_pkg::deem_access_t access,
   output logic [23:0] sp,
   output logic [7:0] run_task
);
   always @(posedge clk) begin
      sp <= sp_req;
      run_task <= task_req;
   end
   // Idle bus flips the address so a stale value never looks current
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         access <= '0;
      else
         access <= req.valid ? req : {5'h00, ~access.addr};
   end
endmodule

// ==== test/deem_monitor_assertions.sv ====
// Checker for the event monitor: counter steps, event causes and routing.
// Assumes it is bound to the monitor top and sees only its ports.
`timescale 1ns/1ps
module deem_monitor_assertions (
   input wire logic clk,
   input wire logic rstn,
   input wire deem_pkg::deem_res_t res_sel,
   input wire logic clear,
   input wire deem_pkg::deem_access_t access,
   input wire logic [7:0] run_task,
   input wire logic trace_write,
   input wire logic trace_full,
   input wire logic [8:0] evt_en,
   input wire logic [8:0] brk_sel,
   input wire logic [39:0] prof_time,
   input wire logic [15:0] prof_count,
   input wire logic [39:0] perf_time,
   input wire logic [8:0] evt_pulse,
   input wire logic [8:0] evt_sticky,
   input wire logic break_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_evt_masked: assert property (
      (evt_pulse & ~$past(evt_en)) == 9'h000)
      else $error("event pulse while disabled");
   a_break_route: assert property (
      break_req |-> |(evt_pulse & $past(brk_sel)))
      else $error("break without a selected event");
   // Sticky bits may only fall on clear, resolution change or mask change
   a_sticky_hold: assert property (
      (!clear && !$past(clear) && $stable(res_sel) && $stable(evt_en)
      && $past(res_sel, 2) == res_sel)
      |-> (evt_sticky & $past(evt_sticky)) == $past(evt_sticky))
      else $error("sticky flag dropped without clear");
   a_count_step: assert property (
      prof_count == $past(prof_count) || prof_count == 16'h0000
      || prof_count == $past(prof_count) + 16'h0001)
      else $error("call count jumped");
   a_time_step: assert property (
      perf_time - $past(perf_time) <= 40'h00_0000_0002
      || perf_time == 40'h00_0000_0000)
      else $error("time counter jumped");
   a_uninit_cause: assert property (
      evt_pulse[1] |-> $past(access.valid)
      && ($past(access.rd) || $past(access.fetch)))
      else $error("uninitialized event without a read");
   a_trace_cause: assert property (
      evt_pulse[6] |-> $past(trace_write) && $past(trace_full))
      else $error("trace overflow without write while full");
   a_dispatch_cause: assert property (
      evt_pulse[8] |-> $past(run_task) != $past(run_task, 2))
      else $error("dispatch without task change");
   a_ovf_cause: assert property (
      $rose(evt_sticky[5]) |-> prof_count == 16'hFFFF || &prof_time)
      else $error("profile overflow below limits");
endmodule

// ==== test/deem_monitor_tb.sv ====
// Bench for the event monitor: core traffic via the core model, checks
// of events, routing and counters. Assumes a 50 MHz clock, no bus.
`timescale 1ns/1ps
module deem_monitor_tb;
   logic clk = 1'b0, rstn = 1'b0, clear = 1'b0, uni_clear = 1'b0;
   logic prof_active = 1'b0, prof_call = 1'b0, stack_en = 1'b0;
   logic perf_active = 1'b0, perf_enter = 1'b0;
   logic trace_write = 1'b0, trace_full = 1'b0, break_req, trace_point;
   deem_pkg::deem_res_t res_sel = deem_pkg::DEEM_RES_20NS;
   deem_pkg::deem_access_t req = '0, access;
   deem_pkg::deem_prot_cfg_t [15:0] prot_cfg = '0;
   deem_pkg::deem_tstack_cfg_t tstack_cfg = '0;
   logic [31:0] uni_blk_en = 32'h0;
   logic [31:0][23:0] uni_blk_base = '0;
   logic [23:0] sp_req = 24'h000400, sp;
   logic [23:0] stack_lo = 24'h000400, stack_hi = 24'h0004FF;
   logic [7:0] task_req = 8'h01, run_task;
   logic [8:0] evt_en = 9'h1FF, brk_sel = 9'h0FF, trc_sel = 9'h1F0;
   logic [8:0] evt_pulse, evt_sticky;
   logic [39:0] prof_time, perf_time;
   logic [15:0] prof_count, perf_count;
   logic [3:0] prot_exp [5] = '{4'h0, 4'h2, 4'hD, 4'hF, 4'h7};
   logic [2:0] ops [4] = '{3'b100, 3'b010, 3'b001, 3'b100};
   logic [39:0] res_exp [6] = '{40'd320, 40'd160, 40'd80, 40'd40, 40'd20,
      40'd2};
   int failures = 0, samples_checked = 0;
   always #10 clk = ~clk;
   deem_core_model deem_core_model_inst (.clk, .rstn, .req, .sp_req,
      .task_req, .access, .sp, .run_task);
   deem_monitor deem_monitor_inst (.clk, .rstn, .res_sel, .clear,
      .prof_active, .prof_call, .perf_active, .perf_enter, .access,
      .prot_cfg, .uni_blk_en, .uni_blk_base, .uni_clear, .sp, .stack_lo,
      .stack_hi, .stack_en, .tstack_cfg, .run_task, .trace_write,
      .trace_full, .evt_en, .brk_sel, .trc_sel, .prof_time, .prof_count,
      .perf_time, .perf_count, .evt_pulse, .evt_sticky, .break_req,
      .trace_point);
   task automatic cmp(input string what, input logic [39:0] exp, got);
      samples_checked++;
      if (exp !== got) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Core inputs reach the monitor one edge late, through the model
   task automatic evt(input int b, input logic e);
      @(posedge clk) req <= '0;
      @(posedge clk) #1;
      cmp("event", 40'(e), 40'(evt_pulse[b]));
      cmp("break", 40'(e & brk_sel[b]), 40'(break_req));
      cmp("trace point", 40'(e & trc_sel[b]), 40'(trace_point));
   endtask
   task automatic acc(input logic [2:0] op, input logic os,
         input logic [23:0] a, input int b, input logic e);
      @(posedge clk) req <= {1'b1, op, os, a};
      evt(b, e);
   endtask
   task automatic results;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk) #1 cmp("idle sticky", 40'h0, 40'(evt_sticky));
      acc(3'b010, 1'b0, 24'h001080, 0, 1'b0);
      acc(3'b001, 1'b0, 24'h001080, 0, 1'b0);
      @(posedge clk) prot_cfg[0] <= '{1'b1, 24'h001000, 24'h0010FF,
         deem_pkg::DEEM_ATTR_RW};
      for (int at = 0; at < 5; at++) begin
         @(posedge clk) prot_cfg[0].attr <= deem_pkg::deem_attr_t'(at);
         for (int k = 0; k < 4; k++)
            if (!(at == 1 && k == 2))
               acc(ops[k], k == 3, 24'h001080, 0, prot_exp[at][k]);
      end
      acc(3'b010, 1'b0, 24'h001100, 0, 1'b0);
      @(posedge clk) prot_cfg[15] <= '{1'b1, 24'h003000, 24'h0030FF,
         deem_pkg::DEEM_ATTR_NONE};
      acc(3'b100, 1'b0, 24'h0030FF, 0, 1'b1);
      $display("test protection done");
      @(posedge clk) uni_blk_base[31] <= 24'h020000;
      @(posedge clk) uni_blk_en[31] <= 1'b1;
      @(posedge clk) uni_clear <= 1'b1;
      @(posedge clk) uni_clear <= 1'b0;
      acc(3'b100, 1'b0, 24'h020010, 1, 1'b1);
      acc(3'b010, 1'b0, 24'h020010, 1, 1'b0);
      acc(3'b100, 1'b0, 24'h020010, 1, 1'b0);
      acc(3'b100, 1'b0, 24'h0200FF, 1, 1'b1);
      acc(3'b100, 1'b0, 24'h020100, 1, 1'b0);
      $display("test uninitialized done");
      @(posedge clk) stack_en <= 1'b1;
      evt(2, 1'b0);
      @(posedge clk) sp_req <= 24'h000500;
      evt(2, 1'b1);
      @(posedge clk) sp_req <= 24'h000480;
      evt(2, 1'b0);
      @(posedge clk) tstack_cfg <= '{1'b1, 24'h000600, 24'h0006FF, 8'h03};
      task_req <= 8'h03;
      evt(8, 1'b1);
      acc(3'b010, 1'b0, 24'h000610, 7, 1'b0);
      @(posedge clk) task_req <= 8'h05;
      evt(8, 1'b1);
      acc(3'b010, 1'b0, 24'h000610, 7, 1'b1);
      @(posedge clk) evt_en <= 9'h0FF;
      task_req <= 8'h07;
      evt(8, 1'b0);
      @(posedge clk) {trace_write, trace_full} <= 2'b11;
      evt_en <= 9'h1FF;
      @(posedge clk) {trace_write, trace_full} <= 2'b00;
      #1 cmp("trace overflow", 40'h1, 40'(evt_pulse[6]));
      $display("test stack and trace done");
      for (int r = 0; r < 6; r++) begin
         @(posedge clk) res_sel <= deem_pkg::deem_res_t'(r);
         repeat (3) @(posedge clk);
         #1 cmp("cleared time", 40'h0, prof_time);
         @(posedge clk) {prof_active, perf_active} <= 2'b11;
         repeat (160) @(posedge clk);
         {prof_active, perf_active} <= 2'b00;
         @(posedge clk) #1 cmp("prof time", res_exp[r], prof_time);
         cmp("perf time", res_exp[r], perf_time);
      end
      $display("test resolution done");
      @(posedge clk) {prof_call, perf_enter} <= 2'b11;
      repeat (65536) @(posedge clk);
      {prof_call, perf_enter} <= 2'b00;
      repeat (2) @(posedge clk);
      #1 cmp("prof count", 40'hFFFF, 40'(prof_count));
      cmp("perf count", 40'hFFFF, 40'(perf_count));
      cmp("overflow sticky", 40'h30, 40'(evt_sticky & 9'h038));
      @(posedge clk) clear <= 1'b1;
      @(posedge clk) clear <= 1'b0;
      @(posedge clk) #1 cmp("cleared", 40'h0, 40'({prof_count, perf_count}));
      cmp("cleared sticky", 40'h0, 40'(evt_sticky));
      $display("test overflow done");
      results();
   end
endmodule
bind deem_monitor deem_monitor_assertions deem_monitor_assertions_inst (
   .clk, .rstn, .res_sel, .clear, .access, .run_task, .trace_write,
   .trace_full, .evt_en, .brk_sel, .prof_time, .prof_count, .perf_time,
   .evt_pulse, .evt_sticky, .break_req);
